// ---- inc/pio_pkg.sv ----
package pio_pkg;

  // port selectors for write and read strobes
  localparam logic [1:0] PORT_A_SEL = 2'h0;
  localparam logic [1:0] PORT_B_SEL = 2'h1;
  localparam logic [1:0] PORT_C_SEL = 2'h2;

  // latch reset values
  localparam logic [7:0] PORT_A_RESET = 8'hFF;
  localparam logic [7:0] PORT_B_RESET = 8'hFF;
  localparam logic [7:0] PORT_C_RESET = 8'hFF;
  localparam logic [7:0] ALL_ONES     = 8'hFF;

  // port B field layout
  localparam int PB_DIG_LSB    = 0;
  localparam int PB_DIG_MSB    = 1;
  localparam int PB_ANA_LSB    = 2;
  localparam int PB_ANA_MSB    = 7;
  localparam int PB_PULSE0_BIT = 0;
  localparam int PB_PULSE1_BIT = 1;

  // pulled-up pins: two of port B and eight of port C
  localparam int PULLUP_PINS = 10;

  // strong pull-up time, in oscillator periods
  localparam int OSC_PERIOD_NS  = 10;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int STRONG_PERIODS = 2;
  localparam int STRONG_CYCLES_RAW =
    (STRONG_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRONG_CYCLES_INT = (STRONG_CYCLES_RAW < 1) ? 1 : STRONG_CYCLES_RAW;
  localparam logic [2:0] STRONG_CYCLES = 3'(STRONG_CYCLES_INT);
  localparam logic [2:0] STRONG_ZERO   = 3'h0;
  localparam logic [2:0] STRONG_ONE    = 3'h1;

endpackage

// ---- verilog/parallel_io_ports.sv ----
// Contract
// - write strobe loads port bit latches
// - read returns latch or pin per strobe
// - port A carries low address/data externally
// - external access forces port A latches high
// - external access drives port A push-pull
// - port A: latch one floats, zero pulls low
// - port B low pins pulled up or low
// - timer-2 inputs pass only when latch one
// - enabled pulse output overrides port B latch
// - latch rise enables strong pull-up two periods
// - pin forced low drops latching pull-up
// - port B upper pins: one analog, zero digital
// - port B upper pins never driven
// - port C carries upper address byte externally
// - port C push-pull externally, latch unchanged
// - port C: latch one pulled up, zero low
// - enabled peripheral takes pin from general use
// - read-modify-write reads the latch
module parallel_io_ports (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // core write and read strobes
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_sel,
  input  wire logic       rd_latch,
  input  wire logic       rd_pin,
  input  wire logic [1:0] rd_sel,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  // external memory access
  input  wire logic       ext_access,
  input  wire logic [7:0] ext_ad_out,
  input  wire logic       ext_ad_drive,
  input  wire logic [7:0] ext_addr_hi,
  // alternate functions on port B low pins
  input  wire logic       pulse_zero_en,
  input  wire logic       pulse_out_zero,
  input  wire logic       pulse_one_en,
  input  wire logic       pulse_out_one,
  output logic            timer2_count_input,
  output logic            timer2_capture_trigger,
  // port A pins
  input  wire logic [7:0] port_a_in,
  output logic      [7:0] port_a_out,
  output logic      [7:0] port_a_oe_n,
  // port B pins
  input  wire logic [7:0] port_b_in,
  output logic      [1:0] port_b_out,
  output logic      [1:0] port_b_oe_n,
  output logic      [1:0] port_b_strong_pullup_fet,
  output logic      [1:0] port_b_latching_pullup_fet,
  output logic      [1:0] port_b_very_weak_pullup_fet,
  output logic      [5:0] port_b_analog_sel,
  // port C pins
  input  wire logic [7:0] port_c_in,
  output logic      [7:0] port_c_out,
  output logic      [7:0] port_c_oe_n,
  output logic      [7:0] port_c_strong_pullup_fet,
  output logic      [7:0] port_c_latching_pullup_fet,
  output logic      [7:0] port_c_very_weak_pullup_fet
);

  // one-hot decode of a port selector, used for writes and reads
  function automatic logic [2:0] port_decode(input logic [1:0] sel);
    logic [2:0] hot;
    hot = 3'h0;
    case (sel)
      pio_pkg::PORT_A_SEL: hot = 3'h1;
      pio_pkg::PORT_B_SEL: hot = 3'h2;
      pio_pkg::PORT_C_SEL: hot = 3'h4;
      default:             hot = 3'h0;
    endcase
    return hot;
  endfunction

  logic [7:0] port_a_latch_q;
  logic [7:0] port_a_latch_d;
  logic [7:0] port_b_latch_q;
  logic [7:0] port_b_latch_d;
  logic [7:0] port_c_latch_q;
  logic [7:0] port_c_latch_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic       rd_valid_q;

  wire logic [2:0] wr_hot;
  wire logic [2:0] rd_hot;
  wire logic       wr_a;
  wire logic       wr_b;
  wire logic       wr_c;

  assign wr_hot = wr_en ? port_decode(wr_sel) : 3'h0;
  assign rd_hot = port_decode(rd_sel);
  assign wr_a   = wr_hot[0];
  assign wr_b   = wr_hot[1];
  assign wr_c   = wr_hot[2];

  // latch next values; external access wins over a core write on port A
  assign port_a_latch_d = ext_access ? pio_pkg::ALL_ONES :
                          wr_a       ? wr_data : port_a_latch_q;
  assign port_b_latch_d = wr_b ? wr_data : port_b_latch_q;
  // port C latch holds through external accesses
  assign port_c_latch_d = wr_c ? wr_data : port_c_latch_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      port_a_latch_q <= pio_pkg::PORT_A_RESET;
      port_b_latch_q <= pio_pkg::PORT_B_RESET;
      port_c_latch_q <= pio_pkg::PORT_C_RESET;
    end else begin
      port_a_latch_q <= port_a_latch_d;
      port_b_latch_q <= port_b_latch_d;
      port_c_latch_q <= port_c_latch_d;
    end
  end

  // read path: latch strobe (used by read-modify-write) beats pin strobe
  wire logic [7:0] sel_latch;
  wire logic [7:0] sel_pin;

  assign sel_latch = rd_hot[0] ? port_a_latch_q :
                     rd_hot[1] ? port_b_latch_q :
                     rd_hot[2] ? port_c_latch_q : 8'h00;
  assign sel_pin   = rd_hot[0] ? port_a_in :
                     rd_hot[1] ? port_b_in :
                     rd_hot[2] ? port_c_in : 8'h00;
  assign rd_data_d = rd_latch ? sel_latch :
                     rd_pin   ? sel_pin   : rd_data_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_data_q  <= rd_data_d;
      rd_valid_q <= rd_latch | rd_pin;
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // port A: open drain in general use, push-pull bus during external access
  assign port_a_out  = ext_access ? ext_ad_out : 8'h00;
  assign port_a_oe_n = ext_access ? {8{~ext_ad_drive}} :
                       port_a_latch_q;

  // port B low pins: pulse output replaces the latch when enabled
  wire logic [1:0] pb_val;

  assign pb_val[pio_pkg::PB_PULSE0_BIT] = pulse_zero_en ? pulse_out_zero :
                                          port_b_latch_q[pio_pkg::PB_PULSE0_BIT];
  assign pb_val[pio_pkg::PB_PULSE1_BIT] = pulse_one_en ? pulse_out_one :
                                          port_b_latch_q[pio_pkg::PB_PULSE1_BIT];

  assign port_b_out  = 2'h0;
  assign port_b_oe_n = pb_val;

  // timer-2 inputs see a pin stuck at zero unless the latch holds one
  assign timer2_count_input     = port_b_latch_q[pio_pkg::PB_PULSE0_BIT] &
                                  port_b_in[pio_pkg::PB_PULSE0_BIT];
  assign timer2_capture_trigger = port_b_latch_q[pio_pkg::PB_PULSE1_BIT] &
                                  port_b_in[pio_pkg::PB_PULSE1_BIT];

  // port B upper pins: input only, latch selects analog or digital
  assign port_b_analog_sel =
    port_b_latch_q[pio_pkg::PB_ANA_MSB:pio_pkg::PB_ANA_LSB];

  // port C: push-pull address bus during external access
  assign port_c_out  = ext_access ? ext_addr_hi : 8'h00;
  assign port_c_oe_n = ext_access ? 8'h00 : port_c_latch_q;

  // pulled-up pins gathered: [1:0] port B low, [9:2] port C
  wire logic [pio_pkg::PULLUP_PINS-1:0] pu_val;
  wire logic [pio_pkg::PULLUP_PINS-1:0] pu_pin;
  wire logic [pio_pkg::PULLUP_PINS-1:0] pu_own;
  logic      [pio_pkg::PULLUP_PINS-1:0] pu_strong;
  logic      [pio_pkg::PULLUP_PINS-1:0] pu_latching;
  logic      [pio_pkg::PULLUP_PINS-1:0] pu_weak;

  assign pu_val = {port_c_latch_q, pb_val};
  assign pu_pin = {port_c_in, port_b_in[pio_pkg::PB_DIG_MSB:pio_pkg::PB_DIG_LSB]};
  // port C pull-ups stand aside while the address bus drives the pins
  assign pu_own = {{8{~ext_access}}, 2'h3};

  generate
    for (genvar i = 0; i < pio_pkg::PULLUP_PINS; i++) begin : g_pullup
      logic [2:0] strong_cnt_q;
      logic [2:0] strong_cnt_d;
      logic       val_q;
      logic       latching_q;
      logic       latching_d;
      wire  logic rise;

      assign rise = pu_val[i] & ~val_q;
      assign strong_cnt_d = !pu_val[i] ? pio_pkg::STRONG_ZERO :
                            rise ? pio_pkg::STRONG_CYCLES :
                            (strong_cnt_q != pio_pkg::STRONG_ZERO) ?
                              strong_cnt_q - pio_pkg::STRONG_ONE :
                              pio_pkg::STRONG_ZERO;
      // latching pull-up holds a high pin, lets go once the pin is seen low
      assign latching_d = pu_val[i] & pu_pin[i];

      always_ff @(posedge clock) begin
        if (!nrst) begin
          strong_cnt_q <= pio_pkg::STRONG_ZERO;
          val_q        <= 1'b1;
          latching_q   <= 1'b0;
        end else begin
          strong_cnt_q <= strong_cnt_d;
          val_q        <= pu_val[i];
          latching_q   <= latching_d;
        end
      end

      assign pu_strong[i]   = pu_own[i] & (strong_cnt_q != pio_pkg::STRONG_ZERO);
      assign pu_latching[i] = pu_own[i] & pu_val[i] & latching_q;
      assign pu_weak[i]     = pu_own[i] & pu_val[i];
    end
  endgenerate

  assign port_b_strong_pullup_fet    = pu_strong[1:0];
  assign port_b_latching_pullup_fet  = pu_latching[1:0];
  assign port_b_very_weak_pullup_fet = pu_weak[1:0];
  assign port_c_strong_pullup_fet    = pu_strong[9:2];
  assign port_c_latching_pullup_fet  = pu_latching[9:2];
  assign port_c_very_weak_pullup_fet = pu_weak[9:2];

endmodule

// ---- verification/port_checker.sv ----
module port_checker (
  // strobes and handshake
  input wire logic       clock, nrst, wr_en, rd_latch, rd_pin, rd_valid,
  input wire logic [1:0] wr_sel, rd_sel,
  input wire logic [7:0] wr_data, rd_data,
  // external access
  input wire logic       ext_access, ext_ad_drive,
  input wire logic [7:0] ext_ad_out, ext_addr_hi,
  // port B
  input wire logic       pulse_zero_en, pulse_out_zero, timer2_count_input,
  input wire logic [1:0] port_b_oe_n,
  input wire logic [5:0] port_b_analog_sel,
  input wire logic [7:0] port_b_in,
  // ports A and C
  input wire logic [7:0] port_a_out, port_a_oe_n, port_c_in, port_c_out, port_c_oe_n,
  input wire logic [7:0] port_c_strong_pullup_fet, port_c_latching_pullup_fet
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_read_answer: assert property ((rd_latch || rd_pin) |=> rd_valid)
    else $error("read strobe got no valid");
  a_rd_refused: assert property ((rd_latch || rd_pin) && rd_sel == 2'h3 |=> rd_data == 8'h00)
    else $error("unused read select returned data");
  a_ext_ad_bus: assert property (ext_access |->
    port_a_out == ext_ad_out && port_a_oe_n == {8{!ext_ad_drive}})
    else $error("port A not on address/data bus");
  a_ext_addr_hi: assert property (ext_access |->
    port_c_out == ext_addr_hi && port_c_oe_n == 8'h00)
    else $error("port C not driving address");
  a_gp_open_drain: assert property (!ext_access |-> (port_a_out & ~port_a_oe_n) == 8'h00)
    else $error("port A drives high outside access");
  a_a_latch_load: assert property (wr_en && wr_sel == pio_pkg::PORT_A_SEL && !ext_access
    ##1 !ext_access |-> port_a_oe_n == $past(wr_data))
    else $error("port A latch write not seen at pins");
  a_analog_sel: assert property (wr_en && wr_sel == pio_pkg::PORT_B_SEL
    |=> port_b_analog_sel == $past(wr_data[7:2]))
    else $error("analog select not loaded");
  a_pulse_wins: assert property (pulse_zero_en |-> port_b_oe_n[0] == pulse_out_zero)
    else $error("pulse output does not own pin");
  a_timer_gate: assert property (!pulse_zero_en |->
    timer2_count_input == (port_b_oe_n[0] && port_b_in[0]))
    else $error("timer input not gated by latch");
  a_strong_two: assert property ($rose(port_c_strong_pullup_fet[0]) |->
    ##1 port_c_strong_pullup_fet[0] ##1 !port_c_strong_pullup_fet[0])
    else $error("strong pull-up not two cycles");
  a_pin_low_drop: assert property (!ext_access && !port_c_in[0]
    |=> !port_c_latching_pullup_fet[0])
    else $error("latching pull-up held on low pin");
endmodule

// ---- verification/pin_world.sv ----
module pin_world (
  // design pin outputs
  input wire logic [7:0] port_a_out, port_a_oe_n, port_c_out, port_c_oe_n,
  input wire logic [1:0] port_b_oe_n,
  // far side: level on released port A pins, port B inputs, port C pins held low
  input wire logic [7:0] ext_a, ext_b, ext_c_low,
  // pin levels seen by the design
  output logic     [7:0] port_a_in, port_b_in, port_c_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // no pull-up on port A: a released pin shows only what the far side drives
  assign port_a_in = (~port_a_oe_n & port_a_out) | (port_a_oe_n & ext_a);
  assign port_b_in = {ext_b[7:2], port_b_oe_n & ext_b[1:0]};
  assign port_c_in = ((~port_c_oe_n & port_c_out) | port_c_oe_n) & ~ext_c_low;
endmodule

// ---- verification/parallel_io_ports_0_to_2_bench.sv ----
module parallel_io_ports_0_to_2_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, nrst = 1'b0, wr_en = 1'b0, rd_latch = 1'b0, rd_pin = 1'b0;
  logic ext_access = 1'b0, ext_ad_drive = 1'b0, pulse_zero_en = 1'b0, pulse_out_zero = 1'b0;
  logic pulse_one_en = 1'b0, pulse_out_one = 1'b0, rd_valid, timer2_count_input;
  logic timer2_capture_trigger;
  logic [1:0] wr_sel = 2'h3, rd_sel = 2'h3, port_b_out, port_b_oe_n, port_b_strong_pullup_fet;
  logic [1:0] port_b_latching_pullup_fet, port_b_very_weak_pullup_fet;
  logic [5:0] port_b_analog_sel;
  logic [7:0] wr_data = 8'h00, ext_ad_out = 8'h00, ext_addr_hi = 8'h00, got, rd_data;
  logic [7:0] ext_a = 8'hFF, ext_b = 8'hFF, ext_c_low = 8'h00, port_a_in, port_b_in;
  logic [7:0] port_c_in, port_a_out, port_a_oe_n, port_c_out, port_c_oe_n;
  logic [7:0] port_c_strong_pullup_fet, port_c_latching_pullup_fet, port_c_very_weak_pullup_fet;
  int fail_count = 0, num_checks = 0, n, strong_cnt = 0;
  parallel_io_ports dut (.*);
  pin_world far (.port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n), .port_c_out(port_c_out),
    .port_c_oe_n(port_c_oe_n), .port_b_oe_n(port_b_oe_n), .ext_a(ext_a), .ext_b(ext_b),
    .ext_c_low(ext_c_low), .port_a_in(port_a_in), .port_b_in(port_b_in), .port_c_in(port_c_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask
  task automatic rd(input logic latch, input logic [1:0] sel);
    @(negedge clock);
    rd_latch = latch;
    rd_pin = !latch;
    rd_sel = sel;
    @(negedge clock);
    rd_latch = 1'b0;
    rd_pin = 1'b0;
    got = rd_data;
    chk({7'h00, rd_valid}, 8'h01, "rd_valid");
  endtask
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  always @(negedge clock) if (port_c_strong_pullup_fet[0] === 1'b1) strong_cnt++;
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (8) @(negedge clock);
    nrst = 1'b1;
    for (n = 0; n < 3; n++) begin
      rd(1'b1, n[1:0]);
      chk(got, 8'hFF, "latch after reset");
    end
    rd(1'b0, 2'h3);
    chk(got, 8'h00, "unused select");
    wr(pio_pkg::PORT_A_SEL, 8'h5A);
    ext_a = 8'h0F;
    rd(1'b0, pio_pkg::PORT_A_SEL);
    chk(got, 8'h0A, "port A pins");
    rd(1'b1, pio_pkg::PORT_A_SEL);
    chk(got, 8'h5A, "port A latch");
    wr(pio_pkg::PORT_C_SEL, 8'h00);
    strong_cnt = 0;
    wr(pio_pkg::PORT_C_SEL, 8'hC3);
    ext_c_low = 8'h01;
    rd(1'b0, pio_pkg::PORT_C_SEL);
    chk(got, 8'hC2, "port C pins");
    chk(port_c_latching_pullup_fet, 8'hC2, "port C latching pull-ups");
    chk(port_c_very_weak_pullup_fet, 8'hC3, "port C weak pull-ups");
    rd(1'b1, pio_pkg::PORT_C_SEL);
    chk(got, 8'hC3, "port C latch");
    chk(8'(strong_cnt), 8'h02, "strong pull-up cycles");
    ext_c_low = 8'h00;
    ext_b = 8'hA5;
    wr(pio_pkg::PORT_B_SEL, 8'h01);
    rd(1'b0, pio_pkg::PORT_B_SEL);
    chk(got, 8'hA5, "port B pins");
    chk({2'h0, port_b_analog_sel}, 8'h00, "analog select");
    chk({6'h00, timer2_capture_trigger, timer2_count_input}, 8'h01, "timer inputs");
    chk({port_b_out, port_b_strong_pullup_fet, port_b_latching_pullup_fet,
         port_b_very_weak_pullup_fet}, 8'h05, "port B pull-ups");
    @(negedge clock);
    pulse_zero_en = 1'b1;
    pulse_one_en = 1'b1;
    pulse_out_one = 1'b1;
    @(negedge clock);
    chk({6'h00, port_b_oe_n}, 8'h02, "pulse drives pin");
    pulse_zero_en = 1'b0;
    pulse_one_en = 1'b0;
    ext_access = 1'b1;
    ext_ad_drive = 1'b1;
    ext_ad_out = 8'hA5;
    ext_addr_hi = 8'h3C;
    wr(pio_pkg::PORT_A_SEL, 8'h00);
    rd(1'b0, pio_pkg::PORT_A_SEL);
    chk(got, 8'hA5, "port A bus");
    rd(1'b0, pio_pkg::PORT_C_SEL);
    chk(got, 8'h3C, "port C address");
    @(negedge clock);
    ext_access = 1'b0;
    ext_ad_drive = 1'b0;
    rd(1'b1, pio_pkg::PORT_A_SEL);
    chk(got, 8'hFF, "port A forced ones");
    rd(1'b1, pio_pkg::PORT_C_SEL);
    chk(got, 8'hC3, "port C latch kept");
    close_out();
  end
endmodule
bind parallel_io_ports port_checker watch (.*);
